// ### shared/standalone_pkg.sv
package standalone_pkg;

  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned SWITCH_ON_S    = 10;
  localparam int unsigned ARM_DELAY_MS   = 8;
  localparam int unsigned OFF_SUPPLY_S   = 30;
  localparam int unsigned TICK_DIV       = CLK_HZ / 1000;
  localparam int unsigned SWITCH_ON_MS   = SWITCH_ON_S * 1000;
  localparam int unsigned OP_PRESET_MIN  = 30;
  localparam int unsigned OP_PRESET_AUTO = 60;
  localparam int unsigned PRESET_MAX     = 9999;
  localparam int unsigned SB_PRESET_MIN  = 30;
  localparam logic [13:0] OP_PRESET_RST  = 14'h003C;
  localparam logic [13:0] SB_PRESET_RST  = 14'h1C20;

  typedef enum logic [2:0] {
    ST_SLEEP   = 3'b000,
    ST_WARMUP  = 3'b001,
    ST_STANDBY = 3'b010,
    ST_ARMING  = 3'b011,
    ST_OPER    = 3'b100,
    ST_SAFE    = 3'b101
  } seq_state_t;

  typedef enum logic [1:0] {
    CMD_NONE  = 2'b00,
    CMD_STOP  = 2'b01,
    CMD_OFF   = 2'b10,
    CMD_OTHER = 2'b11
  } host_cmd_t;

endpackage

// ### logic/standalone_mode_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Sleep to standby after 10 s, variant start
// - Powerup variant: first standby trigger arms, 8 ms
// - Trigger variant: second trigger arms after 8 ms
// - Arming trigger fires no laser shot
// - Operation: one shot per trigger, HV on
// - Operation idle lapse returns to standby
// - Trigger variant: standby idle lapse sleeps
// - Outputs fixed per state
// - Safety key open forces sleep from warm-up, standby, arming and operation
// - Only stop and off commands accepted
// - After shutdown command, safe until reset
// - Report state and stand-alone flag
// - Operation idle preset 30..60 s, host 9999
// - Standby idle preset 30..9999 s, standby only
module standalone_mode_sequencer
  import standalone_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_DIV
)
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        trigger_standby_variant,
  input  wire logic        trigger_pulse,
  input  wire logic        safety_key_closed,
  input  wire logic        host_preset_mode,
  input  wire logic [13:0] op_preset_s,
  input  wire logic [13:0] sb_preset_s,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_code,
  output logic             cmd_accept,
  output logic             cmd_reject,
  output logic             ventilation_on,
  output logic             preionisation_on,
  output logic             hv_on,
  output logic             laser_fire,
  output logic [2:0]       state_code,
  output logic             standalone_active,
  output logic             safe_state
);

  seq_state_t  st_q, st_d;
  logic [16:0] div_q, div_d;
  logic        ms_tick;
  logic [13:0] ms_q, ms_d;
  logic [9:0]  sub_q, sub_d;
  logic [13:0] sec_q, sec_d;
  logic        fire_q, fire_d;
  logic        stop_cmd, off_cmd;
  logic [13:0] op_limit, sb_limit;
  logic        quiet;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  function automatic logic [13:0] clamp_preset(
    input logic [13:0] v, input logic [13:0] lo, input logic [13:0] hi);
    if (v < lo) clamp_preset = lo;
    else if (v > hi) clamp_preset = hi;
    else clamp_preset = v;
  endfunction

  // Operation preset is held to 30..60 s unless host_preset_mode (then 30..9999 s); standby preset to 30..9999 s
  always_comb begin
    op_limit = clamp_preset(op_preset_s, 14'(OP_PRESET_MIN),
      host_preset_mode ? 14'(PRESET_MAX) : 14'(OP_PRESET_AUTO));
    sb_limit = clamp_preset(sb_preset_s, 14'(SB_PRESET_MIN),
      14'(PRESET_MAX));
  end

  assign ms_tick = (div_q == 17'(TICK_CYCLES - 1));

  // Host commands are combinational handshake answers
  always_comb begin
    stop_cmd   = cmd_valid && (cmd_code == CMD_STOP);
    off_cmd    = cmd_valid && (cmd_code == CMD_OFF);
    cmd_accept = stop_cmd || off_cmd;
    cmd_reject = cmd_valid && !cmd_accept;
  end

  always_comb begin
    st_d   = st_q;
    div_d  = ms_tick ? 17'h00000 : div_q + 17'h00001;
    ms_d   = ms_q;
    sub_d  = sub_q;
    sec_d  = sec_q;
    fire_d = 1'b0;
    if (ms_tick) begin
      if (sub_q == 10'h3E7) begin
        sub_d = 10'h000;
        sec_d = sec_q + 14'h0001;
      end else begin
        sub_d = sub_q + 10'h001;
      end
      ms_d = ms_q + 14'h0001;
    end
    case (st_q)
      ST_SLEEP: begin
        if ((!trigger_standby_variant && safety_key_closed) ||
            trigger_pulse) begin
          st_d = ST_WARMUP;
          ms_d = 14'h0000;
        end
      end
      ST_WARMUP: begin
        if (ms_tick && ms_q == 14'(SWITCH_ON_MS - 1)) begin
          st_d  = ST_STANDBY;
          sub_d = 10'h000;
          sec_d = 14'h0000;
        end
      end
      ST_STANDBY: begin
        // In the trigger variant the warm-up trigger was the first and this one is the second; in the powerup variant this is the first
        if (trigger_pulse) begin
          st_d = ST_ARMING;
          ms_d = 14'h0000;
        end else if (trigger_standby_variant && sec_q >= sb_limit) begin
          st_d = ST_SLEEP;
        end
      end
      ST_ARMING: begin
        // Triggers during the 8 ms arm delay are dropped
        if (ms_tick && ms_q == 14'(ARM_DELAY_MS - 1)) begin
          st_d  = ST_OPER;
          sub_d = 10'h000;
          sec_d = 14'h0000;
        end
      end
      ST_OPER: begin
        if (trigger_pulse) begin
          fire_d = 1'b1;
          sub_d  = 10'h000;
          sec_d  = 14'h0000;
        end else if (sec_q >= op_limit) begin
          st_d  = ST_STANDBY;
          sub_d = 10'h000;
          sec_d = 14'h0000;
        end
      end
      ST_SAFE: st_d = ST_SAFE;
      default: st_d = ST_SLEEP;
    endcase
    if (st_q != ST_SAFE && !safety_key_closed &&
        st_q != ST_SLEEP) begin
      st_d   = ST_SLEEP;
      fire_d = 1'b0;
    end
    if (stop_cmd || off_cmd) begin
      st_d   = ST_SAFE;
      fire_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_q   <= ST_SLEEP;
      div_q  <= 17'h00000;
      ms_q   <= 14'h0000;
      sub_q  <= 10'h000;
      sec_q  <= 14'h0000;
      fire_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      div_q  <= div_d;
      ms_q   <= ms_d;
      sub_q  <= sub_d;
      sec_q  <= sec_d;
      fire_q <= fire_d;
    end
  end

  // Safe state keeps everything off until power-on reset
  always_comb begin
    ventilation_on   = st_q inside {ST_STANDBY, ST_ARMING, ST_OPER};
    preionisation_on = ventilation_on;
    hv_on            = (st_q == ST_OPER);
    laser_fire       = fire_q;
    state_code       = st_q;
    standalone_active = 1'b1;
    safe_state       = (st_q == ST_SAFE);
  end

  // Commands override every normal step, an open key every one but a trigger start from sleep
  assign quiet = safety_key_closed && !cmd_valid;

  sequence s_arm_trig;
    st_q == ST_STANDBY && trigger_pulse && quiet;
  endsequence
  sequence s_oper_trig;
    st_q == ST_OPER && trigger_pulse && quiet;
  endsequence
  sequence s_shot;
    laser_fire && hv_on;
  endsequence
  sequence s_warm_end;
    st_q == ST_WARMUP && quiet && ms_tick && ms_q == 14'(SWITCH_ON_MS - 1);
  endsequence
  sequence s_arm_end;
    st_q == ST_ARMING && quiet && ms_tick && ms_q == 14'(ARM_DELAY_MS - 1);
  endsequence
  sequence s_op_lapse;
    st_q == ST_OPER && !trigger_pulse && quiet && sec_q >= op_limit;
  endsequence
  sequence s_sb_lapse;
    st_q == ST_STANDBY && trigger_standby_variant && !trigger_pulse &&
    quiet && sec_q >= sb_limit;
  endsequence

  chk_arm_no_shot: assert property (
    s_arm_trig |=> st_q == ST_ARMING && !laser_fire)
    else $error("arming trigger fired or did not arm");

  chk_oper_fire: assert property (
    s_oper_trig |=> s_shot)
    else $error("trigger in operation gave no shot");

  chk_shot_once: assert property (
    s_oper_trig ##1 !trigger_pulse |=> !laser_fire)
    else $error("one trigger gave more than one shot");

  chk_no_idle_fire: assert property (
    laser_fire |-> $past(st_q) == ST_OPER)
    else $error("shot outside operation");

  chk_sleep_no_oper: assert property (
    st_q == ST_SLEEP |=> st_q != ST_OPER)
    else $error("sleep went straight to operation");

  chk_sleep_wait: assert property (
    (st_q == ST_SLEEP && trigger_standby_variant && !trigger_pulse &&
     !cmd_valid) |=> st_q == ST_SLEEP)
    else $error("trigger variant left sleep with no trigger");

  chk_auto_start: assert property (
    (st_q == ST_SLEEP && !trigger_standby_variant && quiet)
    |=> st_q == ST_WARMUP)
    else $error("powerup variant did not start warm-up");

  chk_warm_done: assert property (
    s_warm_end |=> st_q == ST_STANDBY && sec_q == 14'h0000)
    else $error("warm-up did not end in standby");

  chk_arm_done: assert property (
    s_arm_end |=> st_q == ST_OPER)
    else $error("arm delay did not reach operation");

  chk_arm_hold: assert property (
    (st_q == ST_ARMING && quiet &&
     !(ms_tick && ms_q == 14'(ARM_DELAY_MS - 1)))
    |=> st_q == ST_ARMING && !laser_fire)
    else $error("arming left early or fired");

  chk_op_lapse: assert property (
    s_op_lapse |=> st_q == ST_STANDBY && !hv_on)
    else $error("operation idle lapse did not return to standby");

  chk_op_restart: assert property (
    s_oper_trig |=> sec_q == 14'h0000)
    else $error("operation idle timer not restarted");

  chk_sb_lapse: assert property (
    s_sb_lapse |=> st_q == ST_SLEEP)
    else $error("standby idle lapse did not sleep");

  chk_auto_no_sb: assert property (
    (st_q == ST_STANDBY && !trigger_standby_variant && !trigger_pulse &&
     quiet) |=> st_q == ST_STANDBY)
    else $error("powerup variant left standby on idle");

  chk_key_sleep: assert property (
    (st_q inside {ST_STANDBY, ST_ARMING, ST_OPER} && !safety_key_closed &&
     !cmd_valid) |=> st_q == ST_SLEEP)
    else $error("safety key did not force sleep");

  chk_safe_enter: assert property (
    cmd_accept |=> safe_state)
    else $error("accepted command did not reach safe state");

  chk_safe_hold: assert property (
    safe_state |=> safe_state && !hv_on && !ventilation_on && !laser_fire)
    else $error("safe state left before reset");

  chk_cmd_filter: assert property (
    (cmd_valid && !(cmd_code inside {CMD_STOP, CMD_OFF}))
    |-> cmd_reject && !cmd_accept)
    else $error("other command accepted");

  chk_cmd_no_effect: assert property (
    (cmd_reject && !safe_state) |=> !safe_state)
    else $error("rejected command changed state");

  chk_out_sleep: assert property (
    st_q == ST_SLEEP |-> !ventilation_on && !hv_on)
    else $error("sleep outputs wrong");

  chk_out_standby: assert property (
    st_q == ST_STANDBY |-> ventilation_on && preionisation_on && !hv_on)
    else $error("standby outputs wrong");

  chk_out_oper: assert property (
    st_q == ST_OPER |-> ventilation_on && preionisation_on && hv_on)
    else $error("operation outputs wrong");

  chk_preset_window: assert property (
    op_limit >= 14'(OP_PRESET_MIN) && sb_limit >= 14'(SB_PRESET_MIN) &&
    sb_limit <= 14'(PRESET_MAX) &&
    (host_preset_mode || op_limit <= 14'(OP_PRESET_AUTO)))
    else $error("idle preset outside its window");

endmodule

`default_nettype wire

// ### verification/trigger_source.sv
`timescale 1ns/1ns
`default_nettype none
module trigger_source (
  input  wire logic       ref_clk,
  input  wire logic       req,
  input  wire logic [3:0] gap,
  output logic            trigger_pulse
);
  logic [3:0] cnt_q;
  logic       busy_q;
  initial begin
    cnt_q = 4'h0;
    busy_q = 1'b0;
    trigger_pulse = 1'b0;
  end
  // One-cycle pulse, late by gap cycles to mimic a slow source
  always @(negedge ref_clk) begin
    trigger_pulse <= busy_q && cnt_q == 4'h0;
    if (req && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q <= gap;
    end else if (busy_q) begin
      if (cnt_q == 4'h0)
        busy_q <= 1'b0;
      else
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import standalone_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        variant = 1'b0;
  logic        key = 1'b1;
  logic        hmode = 1'b0;
  logic        cv = 1'b0;
  logic        req = 1'b0;
  logic [1:0]  code = 2'h0;
  logic [3:0]  gap = 4'h0;
  logic [13:0] op_p = 14'h003C;
  logic [13:0] sb_p = 14'h1C20;
  logic        trg, acc, rej, vent, pre, hv, fire, act, safe;
  logic [2:0]  st;
  logic [8:0]  n;
  logic [8:0]  notes[$];
  localparam int unsigned LAPSE    = OP_PRESET_MIN * 1000;
  localparam int unsigned SB_LAPSE = SB_PRESET_MIN * 1000;
  localparam int          CEILING  = 98000;
  logic [31:0] rng = 32'h0000C920;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          i;
  always #5 ref_clk = ~ref_clk;
  trigger_source src (.ref_clk(ref_clk), .req(req), .gap(gap),
    .trigger_pulse(trg));
  standalone_mode_sequencer #(.TICK_CYCLES(1)) DUT (.ref_clk(ref_clk),
    .rstn(rstn),
    .trigger_standby_variant(variant), .trigger_pulse(trg),
    .safety_key_closed(key), .host_preset_mode(hmode),
    .op_preset_s(op_p), .sb_preset_s(sb_p), .cmd_valid(cv),
    .cmd_code(code), .cmd_accept(acc), .cmd_reject(rej),
    .ventilation_on(vent), .preionisation_on(pre), .hv_on(hv),
    .laser_fire(fire), .state_code(st), .standalone_active(act),
    .safe_state(safe));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Note layout: fire, accept, reject, safe, hv, vent, state
  // A note holds the outputs after the edge that follows its stimulus
  task automatic step(input logic c, input logic [1:0] k, input logic kv,
                      input logic [8:0] note);
    @(negedge ref_clk);
    rng = xs(rng);
    cv <= c;
    code <= k;
    key <= kv;
    gap <= rng[3:0];
    @(posedge ref_clk);
    notes.push_back(note);
  endtask
  task automatic presets;
    @(negedge ref_clk);
    rng = xs(rng);
    hmode <= rng[20];
    op_p <= rng[13:0] % 14'h001E;
    sb_p <= rng[29:16] % 14'h001E;
  endtask
  // Source delay is random, so wait for the edge that takes the pulse
  task automatic trig(input logic [8:0] note);
    @(negedge ref_clk);
    rng = xs(rng);
    req <= 1'b1;
    gap <= rng[3:0];
    @(negedge ref_clk);
    req <= 1'b0;
    do @(posedge ref_clk); while (trg !== 1'b1);
    notes.push_back(note);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == CEILING) begin
      n_mismatch++;
      close_out();
    end
  end
  // Falling edge: outputs settled, new stimulus not yet applied
  always @(negedge ref_clk) begin
    check({2'b00, fire && !hv}, 3'h0);
    if (notes.size() > 0) begin
      n = notes.pop_front();
      check(st, n[2:0]);
      check({pre, vent, hv}, {n[3], n[3], n[4]});
      check({1'b0, acc, rej}, {1'b0, n[7], n[6]});
      check({fire, safe, act}, {n[8], n[5], 1'b1});
    end
  end
  initial begin
    presets();
    repeat (11) @(negedge ref_clk);
    rstn <= 1'b1;
    step(1'b0, 2'h0, 1'b1, {6'h00, ST_WARMUP});
    step(1'b1, 2'h0, 1'b1, {6'h08, ST_WARMUP});
    step(1'b1, 2'h3, 1'b1, {6'h08, ST_WARMUP});
    step(1'b0, 2'h0, 1'b1, {6'h00, ST_WARMUP});
    repeat (SWITCH_ON_MS - 20) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h00, ST_WARMUP});
    repeat (30) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h01, ST_STANDBY});
    trig({6'h01, ST_ARMING});
    step(1'b0, 2'h0, 1'b1, {6'h01, ST_ARMING});
    repeat (10) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h03, ST_OPER});
    for (i = 0; i < 3; i++) begin
      trig({6'h23, ST_OPER});
      step(1'b0, 2'h0, 1'b1, {6'h03, ST_OPER});
    end
    repeat (LAPSE - 40) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h03, ST_OPER});
    repeat (60) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h01, ST_STANDBY});
    trig({6'h01, ST_ARMING});
    repeat (10) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h03, ST_OPER});
    step(1'b0, 2'h0, 1'b0, {6'h00, ST_SLEEP});
    step(1'b0, 2'h0, 1'b0, {6'h00, ST_SLEEP});
    step(1'b1, 2'h1, 1'b0, {6'h14, ST_SAFE});
    step(1'b0, 2'h0, 1'b1, {6'h04, ST_SAFE});
    trig({6'h04, ST_SAFE});
    step(1'b1, 2'h2, 1'b1, {6'h14, ST_SAFE});
    step(1'b1, 2'h3, 1'b1, {6'h0C, ST_SAFE});
    step(1'b0, 2'h0, 1'b1, {6'h04, ST_SAFE});
    @(negedge ref_clk);
    rstn <= 1'b0;
    variant <= 1'b1;
    repeat (12) @(negedge ref_clk);
    rstn <= 1'b1;
    step(1'b0, 2'h0, 1'b1, {6'h00, ST_SLEEP});
    step(1'b0, 2'h0, 1'b1, {6'h00, ST_SLEEP});
    trig({6'h00, ST_WARMUP});
    repeat (SWITCH_ON_MS + 20) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h01, ST_STANDBY});
    repeat (SB_LAPSE - 60) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h01, ST_STANDBY});
    repeat (80) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h00, ST_SLEEP});
    trig({6'h00, ST_WARMUP});
    repeat (SWITCH_ON_MS + 20) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h01, ST_STANDBY});
    trig({6'h01, ST_ARMING});
    repeat (10) @(negedge ref_clk);
    step(1'b0, 2'h0, 1'b1, {6'h03, ST_OPER});
    trig({6'h23, ST_OPER});
    // Orderly shutdown: stop first, then off
    step(1'b1, 2'h1, 1'b1, {6'h14, ST_SAFE});
    step(1'b1, 2'h2, 1'b1, {6'h14, ST_SAFE});
    step(1'b0, 2'h0, 1'b1, {6'h04, ST_SAFE});
    @(negedge ref_clk);
    close_out();
  end
endmodule
`default_nettype wire
